// ===== design/icm_i2c_master.sv
// byte oriented i2c master with address, data and status registers
module icm_i2c_master
  import icm_pkg::*;
#(
  parameter int QTR_CYC = QTR_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire icm_bus_t   bus_in,
  output logic [7:0]      rdata_out,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            tx_irq_out,
  output logic            rx_irq_out
);

  icm_st_t st_reg;
  icm_st_t st_next;
  logic    busy;
  logic    stall;
  logic    tick;
  logic    last_q;

  localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(QTR_CYC - 1);

  function automatic logic [7:0] status_byte(input icm_st_t s);
    logic [7:0] v;
    v = 8'h00;
    v[STAT_SWR_BIT] = s.stop_after_write;
    v[STAT_SRD_BIT] = s.stop_after_read;
    v[STAT_TXE_BIT] = s.transmitter_empty_flag;
    v[STAT_ERR_BIT] = s.err;
    v[STAT_RXF_BIT] = s.receiver_full_flag;
    return v;
  endfunction

  // open drain: a zero bit means pull the line low
  function automatic logic pull_for(input logic b);
    return !b;
  endfunction

  assign busy   = (st_reg.state != ST_IDLE) && (st_reg.state != ST_HOLD);
  // slave stretching: wait while released clock still reads low
  assign stall  = (st_reg.qph == 2'd1) && !st_reg.scl_oe && !st_reg.scl_lvl;
  assign tick   = busy && !stall && (st_reg.div == DIV_TOP);
  assign last_q = tick && (st_reg.qph == 2'd3);

  always_comb begin
    st_next        = st_reg;
    st_next.tx_irq = 1'b0;
    st_next.rx_irq = 1'b0;
    st_next.rdata  = 8'h00;
    // pin synchronisers, level taken when stages two and three agree
    st_next.scl_sy = {st_reg.scl_sy[1:0], scl_in};
    st_next.sda_sy = {st_reg.sda_sy[1:0], sda_in};
    if (st_reg.scl_sy[2] == st_reg.scl_sy[1]) begin
      st_next.scl_lvl = st_reg.scl_sy[2];
    end
    if (st_reg.sda_sy[2] == st_reg.sda_sy[1]) begin
      st_next.sda_lvl = st_reg.sda_sy[2];
    end

    // register writes
    if (bus_in.wr) begin
      if (bus_in.addr == ADR_TARGET) begin
        st_next.tadr = bus_in.wdata;
        if (st_reg.state != ST_IDLE) begin
          st_next.addr_dirty = 1'b1;
        end
      end else if (bus_in.addr == ADR_TRANSMIT) begin
        if (st_reg.transmitter_empty_flag) begin
          st_next.txd     = bus_in.wdata;
          st_next.pending = 1'b1;
          st_next.transmitter_empty_flag     = 1'b0;
        end
      end else if (bus_in.addr == ADR_STATUS) begin
        st_next.stop_after_write = bus_in.wdata[STAT_SWR_BIT];
        st_next.stop_after_read = bus_in.wdata[STAT_SRD_BIT];
        if (bus_in.wdata[STAT_ERR_BIT]) begin
          st_next.err = 1'b0;
        end
      end
    end

    // register reads, data in the following cycle only
    if (bus_in.rd) begin
      if (bus_in.addr == ADR_TARGET) begin
        st_next.rdata = st_reg.tadr;
      end else if (bus_in.addr == ADR_RECEIVE) begin
        st_next.rdata = st_reg.rxd;
        st_next.receiver_full_flag   = 1'b0;
      end else if (bus_in.addr == ADR_TRANSMIT) begin
        st_next.rdata = st_reg.txd;
      end else if (bus_in.addr == ADR_STATUS) begin
        st_next.rdata = status_byte(st_reg);
      end
    end

    // quarter bit divider
    if (busy && !stall) begin
      st_next.div = tick ? '0 : st_reg.div + 1'b1;
    end

    if (tick) begin
      st_next.qph = st_reg.qph + 2'd1;
      case (st_reg.qph)
        2'd0: begin
          st_next.scl_oe = 1'b0;
        end
        2'd1: begin
          case (st_reg.state)
            ST_START: st_next.sda_oe = 1'b1;
            ST_TACK:  st_next.ack_bit = st_reg.sda_lvl;
            ST_RECV:  st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_lvl};
            default:  st_next.ack_bit = st_reg.ack_bit;
          endcase
        end
        2'd2: begin
          if (st_reg.state == ST_STOP) begin
            st_next.sda_oe = 1'b0;
          end else begin
            st_next.scl_oe = 1'b1;
          end
        end
        default: begin
          case (st_reg.state)
            ST_START: begin
              st_next.state      = ST_SHIFT;
              st_next.shreg      = st_reg.tadr;
              st_next.addr_phase = 1'b1;
              st_next.bitn       = 3'h0;
              st_next.sda_oe     = pull_for(st_reg.tadr[7]);
            end
            ST_SHIFT: begin
              if (st_reg.bitn == LAST_BIT) begin
                st_next.state  = ST_TACK;
                st_next.bitn   = 3'h0;
                st_next.sda_oe = 1'b0;
              end else begin
                st_next.bitn   = st_reg.bitn + 3'h1;
                st_next.shreg  = {st_reg.shreg[6:0], 1'b0};
                st_next.sda_oe = pull_for(st_reg.shreg[6]);
              end
            end
            ST_TACK: begin
              if (st_reg.ack_bit) begin
                st_next.err     = 1'b1;
                st_next.transmitter_empty_flag     = 1'b1;
                st_next.tx_irq  = 1'b1;
                st_next.pending = 1'b0;
                st_next.state   = ST_STOP;
                st_next.sda_oe  = 1'b1;
              end else if (st_reg.addr_phase && st_reg.rd_mode) begin
                st_next.addr_phase = 1'b0;
                st_next.pending    = 1'b0;
                st_next.transmitter_empty_flag        = 1'b1;
                st_next.tx_irq     = 1'b1;
                st_next.state      = ST_RECV;
                st_next.sda_oe     = 1'b0;
              end else if (st_reg.addr_phase) begin
                st_next.addr_phase = 1'b0;
                st_next.state      = ST_SHIFT;
                st_next.shreg      = st_reg.txd;
                st_next.sda_oe     = pull_for(st_reg.txd[7]);
              end else begin
                st_next.pending = 1'b0;
                st_next.transmitter_empty_flag     = 1'b1;
                st_next.tx_irq  = 1'b1;
                if (st_reg.stop_after_write) begin
                  st_next.state  = ST_STOP;
                  st_next.sda_oe = 1'b1;
                end else begin
                  st_next.state  = ST_HOLD;
                end
              end
            end
            ST_RECV: begin
              if (st_reg.bitn == LAST_BIT) begin
                st_next.rxd    = st_reg.shreg;
                st_next.receiver_full_flag    = 1'b1;
                st_next.rx_irq = 1'b1;
                st_next.state  = ST_RACK;
                st_next.bitn   = 3'h0;
                st_next.sda_oe = !st_reg.stop_after_read;
              end else begin
                st_next.bitn   = st_reg.bitn + 3'h1;
              end
            end
            ST_RACK: begin
              // stop follows the byte that was not acknowledged
              if (!st_reg.sda_oe) begin
                st_next.state  = ST_STOP;
                st_next.sda_oe = 1'b1;
              end else begin
                st_next.state  = ST_HOLD;
                st_next.sda_oe = 1'b0;
              end
            end
            default: begin
              st_next.state = ST_IDLE;
            end
          endcase
        end
      endcase
    end else if (!busy) begin
      if (st_reg.pending &&
          (st_reg.state == ST_IDLE || st_reg.addr_dirty || st_reg.rd_mode))
      begin
        st_next.state      = ST_START;
        st_next.rd_mode    = st_reg.tadr[ADR_DIR_BIT];
        st_next.addr_dirty = 1'b0;
        st_next.qph        = 2'd0;
        st_next.div        = '0;
        st_next.sda_oe     = 1'b0;
        if (st_reg.tadr[ADR_DIR_BIT]) begin
          st_next.receiver_full_flag = 1'b0;
        end
      end else if (st_reg.pending) begin
        st_next.state  = ST_SHIFT;
        st_next.shreg  = st_reg.txd;
        st_next.bitn   = 3'h0;
        st_next.qph    = 2'd0;
        st_next.div    = '0;
        st_next.sda_oe = pull_for(st_reg.txd[7]);
      end else if (st_reg.state == ST_HOLD && st_reg.rd_mode &&
                   !st_reg.receiver_full_flag) begin
        st_next.state  = ST_RECV;
        st_next.bitn   = 3'h0;
        st_next.qph    = 2'd0;
        st_next.div    = '0;
        st_next.sda_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= ICM_ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_out  = st_reg.rdata;
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = st_reg.scl_oe;
  assign sda_oe_out = st_reg.sda_oe;
  assign tx_irq_out = st_reg.tx_irq;
  assign rx_irq_out = st_reg.rx_irq;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_tadr_write: assert property (
    bus_in.wr && bus_in.addr == ADR_TARGET
      |=> st_reg.tadr == $past(bus_in.wdata))
    else $error("address register not written");

  a_rx_readback: assert property (
    bus_in.rd && bus_in.addr == ADR_RECEIVE |=> rdata_out == $past(st_reg.rxd))
    else $error("receive byte read back wrong");

  a_launch_busy: assert property (
    bus_in.wr && bus_in.addr == ADR_TRANSMIT && st_reg.transmitter_empty_flag |=> !st_reg.transmitter_empty_flag
      ##1 !st_reg.transmitter_empty_flag)
    else $error("empty flag not cleared at launch");

  a_idle_start: assert property (
    st_reg.state == ST_IDLE && st_reg.pending |=> st_reg.state == ST_START
      ##1 (st_reg.state == ST_START && !st_reg.sda_oe))
    else $error("launch did not begin with start");

  a_tx_done_flag: assert property (
    tx_irq_out |-> st_reg.transmitter_empty_flag && !st_reg.pending)
    else $error("transmit interrupt without empty flag");

  a_stop_write: assert property (
    last_q && st_reg.state == ST_TACK && !st_reg.addr_phase &&
      !st_reg.ack_bit |=> st_reg.state == (st_reg.stop_after_write ? ST_STOP : ST_HOLD))
    else $error("stop after write choice wrong");

  a_stop_read: assert property (
    last_q && st_reg.state == ST_RACK && !st_reg.sda_oe
      |=> st_reg.state == ST_STOP)
    else $error("no stop after final read");

  a_read_clear: assert property (
    st_reg.state == ST_IDLE && st_reg.pending && st_reg.tadr[ADR_DIR_BIT]
      |=> !st_reg.receiver_full_flag)
    else $error("full flag not cleared at read launch");

  a_rx_full_set: assert property (
    rx_irq_out |-> st_reg.receiver_full_flag && st_reg.state == ST_RACK)
    else $error("receive interrupt without full flag");

  a_rd_clear: assert property (
    bus_in.rd && bus_in.addr == ADR_RECEIVE && !(last_q &&
      st_reg.state == ST_RECV && st_reg.bitn == LAST_BIT) |=> !st_reg.receiver_full_flag)
    else $error("full flag survived a read");

  a_data_only: assert property (
    st_reg.state == ST_HOLD && st_reg.pending && !st_reg.addr_dirty &&
      !st_reg.rd_mode |=> st_reg.state == ST_SHIFT)
    else $error("open transaction restarted");

  a_err_w1c: assert property (
    bus_in.wr && bus_in.addr == ADR_STATUS && bus_in.wdata[STAT_ERR_BIT] &&
      !(last_q && st_reg.state == ST_TACK) |=> !st_reg.err)
    else $error("error flag not cleared by one");

  a_ack_level: assert property (
    last_q && st_reg.state == ST_RECV && st_reg.bitn == LAST_BIT
      |=> sda_oe_out == !$past(st_reg.stop_after_read))
    else $error("wrong acknowledge on received byte");

  a_hold_low: assert property (
    st_reg.state == ST_HOLD |-> scl_oe_out)
    else $error("clock released while holding");

  c_write_stop: cover property (
    st_reg.state == ST_TACK && st_reg.stop_after_write ##1 st_reg.state == ST_STOP);
  c_read_stop: cover property (
    st_reg.state == ST_RACK ##1 st_reg.state == ST_STOP);
  c_seq_read: cover property (
    st_reg.state == ST_HOLD && st_reg.rd_mode ##1 st_reg.state == ST_RECV);
  c_bus_err: cover property ($rose(st_reg.err));

endmodule

// ===== design/icm_pkg.sv
// constants and types for the byte oriented i2c master
package icm_pkg;
  localparam int          ICM_AW           = 2;
  localparam logic [1:0]  ADR_TARGET       = 2'h0;
  localparam logic [1:0]  ADR_RECEIVE      = 2'h1;
  localparam logic [1:0]  ADR_TRANSMIT     = 2'h2;
  localparam logic [1:0]  ADR_STATUS       = 2'h3;
  localparam int          STAT_SWR_BIT     = 0;
  localparam int          STAT_SRD_BIT     = 1;
  localparam int          STAT_TXE_BIT     = 3;
  localparam int          STAT_ERR_BIT     = 5;
  localparam int          STAT_RXF_BIT     = 7;
  localparam int          ADR_DIR_BIT      = 0;
  localparam logic [7:0]  RST_TARGET       = 8'h00;
  localparam logic [7:0]  RST_RECEIVE      = 8'h00;
  localparam logic [7:0]  RST_TRANSMIT     = 8'h00;
  localparam logic        RST_TXE          = 1'b1;
  localparam int          CLK_PERIOD_NS    = 4;
  localparam int          BIT_PERIOD_NS    = 10000;
  localparam int          QTR_CYCLES       = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int          DIV_W            = 16;
  localparam logic [2:0]  LAST_BIT         = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_SHIFT, ST_TACK, ST_RECV, ST_RACK, ST_STOP, ST_HOLD
  } icm_state_t;

  typedef struct packed {
    logic [ICM_AW-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } icm_bus_t;

  typedef struct packed {
    icm_state_t        state;
    logic [1:0]        qph;
    logic [DIV_W-1:0]  div;
    logic [2:0]        bitn;
    logic [7:0]        shreg;
    logic              addr_phase;
    logic              rd_mode;
    logic              addr_dirty;
    logic              pending;
    logic              ack_bit;
    logic              transmitter_empty_flag;
    logic              receiver_full_flag;
    logic              err;
    logic              stop_after_write;
    logic              stop_after_read;
    logic [7:0]        tadr;
    logic [7:0]        rxd;
    logic [7:0]        txd;
    logic [7:0]        rdata;
    logic              scl_oe;
    logic              sda_oe;
    logic [2:0]        scl_sy;
    logic [2:0]        sda_sy;
    logic              scl_lvl;
    logic              sda_lvl;
    logic              tx_irq;
    logic              rx_irq;
  } icm_st_t;

  localparam icm_st_t ICM_ST_RESET = '{state: ST_IDLE, tadr: RST_TARGET,
    rxd: RST_RECEIVE, txd: RST_TRANSMIT, transmitter_empty_flag: RST_TXE, scl_sy: 3'h7,
    sda_sy: 3'h7, scl_lvl: 1'b1, sda_lvl: 1'b1, default: '0};
endpackage

// ===== verification/icm_eeprom_model.sv
// behavioural i2c slave standing on the far side of the master
module icm_eeprom_model #(
  parameter logic [6:0] DEV_ADR  = 7'h50,
  parameter logic [7:0] RD_FIRST = 8'h3c
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] rd_byte = RD_FIRST;
  logic [7:0] got[$];
  int         n = -1;
  logic       act = 1'b0;
  logic       adr_ph;
  logic       rw;
  logic       ok;
  logic       mack;
  initial sda_oe_out = 1'b0;
  // start resets the frame, stop ends it
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    act = 1'b1;
    adr_ph = 1'b1;
    n = -1;
    mack = 1'b0;
    ok = 1'b0;
    rw = 1'b0;
  end
  always @(posedge sda_in) if (scl_in === 1'b1) act = 1'b0;
  always @(posedge scl_in) begin
    if (act && n >= 0 && n < 8)
      sh = {sh[6:0], sda_in};
    if (act && n == 8)
      mack = sda_in;
  end
  // data changes only while the clock is low
  always @(negedge scl_in) if (act) begin
    n = n + 1;
    sda_oe_out = 1'b0;
    if (n == 8 && (adr_ph || !rw)) begin
      if (!adr_ph && ok)
        got.push_back(sh);
      sda_oe_out = adr_ph ? (sh[7:1] == DEV_ADR) : ok;
    end else if (n == 9) begin
      n = 0;
      if (adr_ph) begin
        rw = sh[0];
        ok = (sh[7:1] == DEV_ADR);
      end else if (rw)
        rd_byte = rd_byte + 8'h01;
      adr_ph = 1'b0;
      if (rw && ok && !mack)
        sda_oe_out = ~rd_byte[7];
    end else if (rw && ok && !adr_ph && !mack && n < 8)
      sda_oe_out = ~rd_byte[3'(7 - n)];
  end
endmodule

// ===== verification/icm_i2c_master_tb.sv
// self checking bench for the byte oriented i2c master
`define CHK(what, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("wrong value %s exp %h got %h", what, exp, got); \
  end \
end

module icm_i2c_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import icm_pkg::*;
  localparam int         Q   = 5;
  localparam logic [6:0] DEV = 7'h50;
  localparam logic [7:0] RD0 = 8'h3c;
  localparam logic [7:0] RST_TAB [4] = '{8'h00, 8'h00, 8'h00, 8'h08};
  logic       clk_in;
  logic       nrst_in;
  icm_bus_t   bus;
  logic [7:0] rdata;
  logic       scl_oe;
  logic       sda_oe;
  logic       slv_oe;
  logic       tx_irq;
  logic       rx_irq;
  wire logic  scl_w = ~scl_oe;
  wire logic  sda_w = ~(sda_oe | slv_oe);
  int         err_total = 0;
  int         check_count = 0;
  int         tx_n = 0;
  int         rx_n = 0;
  int         starts = 0;
  int         stops = 0;
  int         s0;
  int         p0;
  int         r0;
  int         t0;
  int         k;
  int         n;
  logic [7:0] v;
  logic [7:0] exp_rd;

  icm_i2c_master #(.QTR_CYC(Q)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .bus_in(bus), .rdata_out(rdata), .scl_in(scl_w), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
    .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
  icm_eeprom_model #(.DEV_ADR(DEV), .RD_FIRST(RD0)) slv_u (.scl_in(scl_w),
    .sda_in(sda_w), .sda_oe_out(slv_oe));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (tx_irq === 1'b1) tx_n++;
    if (rx_irq === 1'b1) rx_n++;
  end
  always @(negedge sda_w) if (scl_w === 1'b1) starts++;
  always @(posedge sda_w) if (scl_w === 1'b1) stops++;

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
    @(posedge clk_in);
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
    #1;
    d = rdata;
    @(posedge clk_in);
  endtask
  task automatic wait_stat(input int b, input logic val);
    logic [7:0] s;
    int i;
    s = 8'h00;
    for (i = 0; i < 3000; i++) begin
      rd_reg(ADR_STATUS, s);
      if (s[b] === val) break;
    end
    `CHK("status flag", val, s[b])
  endtask
  task automatic wait_stop(input int want);
    int i;
    for (i = 0; i < 4000 && stops < want; i++) @(posedge clk_in);
    `CHK("stop seen", want, stops)
    `CHK("pins idle", 2'b00, {scl_oe, sda_oe})
  endtask

  initial begin
    #300000;
    err_total++;
    wrap_up();
  end

  initial begin
    bus = '0;
    nrst_in = 1'b0;
    exp_rd = RD0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    for (k = 0; k < 4; k++) begin
      rd_reg(2'(k), v);
      `CHK("reset value", RST_TAB[k], v)
    end
    wr_reg(ADR_TARGET, 8'ha1);
    rd_reg(ADR_TARGET, v);
    `CHK("target rw", 8'ha1, v)
    wr_reg(ADR_RECEIVE, 8'h5a);
    rd_reg(ADR_RECEIVE, v);
    `CHK("receive ro", 8'h00, v)
    // dummy write of the word address, left open
    wr_reg(ADR_STATUS, 8'h00);
    wr_reg(ADR_TARGET, {DEV, 1'b0});
    s0 = starts;
    t0 = tx_n;
    wr_reg(ADR_TRANSMIT, 8'h12);
    rd_reg(ADR_STATUS, v);
    `CHK("busy", 1'b0, v[STAT_TXE_BIT])
    wait_stat(STAT_TXE_BIT, 1'b1);
    wr_reg(ADR_TRANSMIT, 8'h34);
    wait_stat(STAT_TXE_BIT, 1'b1);
    repeat (4 * Q) @(posedge clk_in);
    `CHK("tx irqs", t0 + 2, tx_n)
    `CHK("one start", s0 + 1, starts)
    `CHK("clock held", 1'b1, scl_oe)
    `CHK("high byte", 8'h12, slv_u.got[0])
    `CHK("low byte", 8'h34, slv_u.got[1])
    // sequential read through a repeated start
    wr_reg(ADR_TARGET, {DEV, 1'b1});
    s0 = starts;
    p0 = stops;
    wr_reg(ADR_TRANSMIT, 8'h00);
    for (k = 0; k < 3; k++) begin
      wait_stat(STAT_RXF_BIT, 1'b1);
      if (k < 2) begin
        rd_reg(ADR_RECEIVE, v);
        `CHK("seq byte", exp_rd, v)
      end
      if (k == 1) wr_reg(ADR_STATUS, 8'h02);
      exp_rd++;
    end
    wait_stop(p0 + 1);
    `CHK("no new address", s0 + 1, starts)
    `CHK("last nack", 1'b1, slv_u.mack)
    // current address read with the full flag still set
    p0 = stops;
    r0 = rx_n;
    wr_reg(ADR_TRANSMIT, 8'h00);
    wait_stat(STAT_RXF_BIT, 1'b0);
    wait_stat(STAT_RXF_BIT, 1'b1);
    rd_reg(ADR_RECEIVE, v);
    `CHK("single byte", exp_rd, v)
    rd_reg(ADR_STATUS, v);
    `CHK("full cleared", 1'b0, v[STAT_RXF_BIT])
    `CHK("rx irq", r0 + 1, rx_n)
    wait_stop(p0 + 1);
    // byte pair with stop after the last, busy write ignored
    wr_reg(ADR_STATUS, 8'h00);
    wr_reg(ADR_TARGET, {DEV, 1'b0});
    n = slv_u.got.size();
    p0 = stops;
    wr_reg(ADR_TRANSMIT, 8'h77);
    wr_reg(ADR_TRANSMIT, 8'h99);
    wait_stat(STAT_TXE_BIT, 1'b1);
    `CHK("no stop yet", p0, stops)
    wr_reg(ADR_STATUS, 8'h01);
    wr_reg(ADR_TRANSMIT, 8'h88);
    wait_stop(p0 + 1);
    `CHK("bytes sent", n + 2, slv_u.got.size())
    `CHK("first data", 8'h77, slv_u.got[n])
    `CHK("last data", 8'h88, slv_u.got[n + 1])
    rd_reg(ADR_TRANSMIT, v);
    `CHK("transmit rw", 8'h88, v)
    // absent slave gives a bus error
    wr_reg(ADR_STATUS, 8'h00);
    wr_reg(ADR_TARGET, {7'h11, 1'b0});
    p0 = stops;
    wr_reg(ADR_TRANSMIT, 8'h42);
    wait_stat(STAT_ERR_BIT, 1'b1);
    wait_stop(p0 + 1);
    wr_reg(ADR_STATUS, 8'h00);
    rd_reg(ADR_STATUS, v);
    `CHK("error kept", 1'b1, v[STAT_ERR_BIT])
    wr_reg(ADR_STATUS, 8'h20);
    rd_reg(ADR_STATUS, v);
    `CHK("error cleared", 1'b0, v[STAT_ERR_BIT])
    wrap_up();
  end
endmodule
